// file: hw/ebt_pkg.sv
/*
 * ebt_pkg: register map, field positions, reset values and timing
 * counts of the eight-bit timer with shared prescaler.
 * Assumes a 32-bit classic Wishbone slave with one register per word.
 */
package ebt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OPTION = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h10;
  // irq_control fields
  localparam int IC_GLOBAL_IRQ_EN = 7;
  localparam int IC_OVF_IRQ_EN = 5;
  localparam int IC_OVF_FLAG = 2;
  // option_config fields
  localparam int OPT_PULLUP_DIS = 7;
  localparam int OPT_INT_EDGE = 6;
  localparam int OPT_CLK_SRC = 5;
  localparam int OPT_SRC_EDGE = 4;
  localparam int OPT_PS_ASSIGN = 3;
  localparam int OPT_RATE_LSB = 0;
  localparam int RATE_W = 3;
  // event status / mask fields
  localparam int EV_OVERFLOW = 0;
  localparam int EV_WATCHDOG = 1;
  localparam int EV_W = 2;
  // reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [EV_W-1:0] RST_EVT_MASK = 2'h0;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PHASES_PER_INSTR = 4;
  localparam int INSTR_NS = CLK_PERIOD_NS * PHASES_PER_INSTR;
  localparam int INHIBIT_INSTR = 2;
  localparam int INHIBIT_NS = INHIBIT_INSTR * INSTR_NS;
  localparam int INHIBIT_CLKS = (INHIBIT_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  // phase codes: 0 = phase one ... 3 = phase four
  localparam logic [1:0] PH_TWO = 2'h1;
  localparam logic [1:0] PH_FOUR = 2'h3;
  typedef enum logic [1:0] {EBT_SRC_INSTR, EBT_SRC_PIN} ebt_src_t;
endpackage

// file: hw/ebt_timer.sv
/*
 * ebt_timer: eight-bit timer/counter with one prescaler shared with the
 * watchdog, register access over classic Wishbone, event interrupt.
 * Assumes all inputs synchronous to ref_clk_in; the watchdog itself sits
 * outside and supplies its oscillator tick and clear strobe.
 */
`timescale 1ns/1ps
// Behaviour
// - overflow event on count rollover FFh to 00h
// - flag sets on rollover regardless of enable
// - timer frozen while sleep is asserted
// - external clock resynchronised at phases two, four
// - source bit selects pin edges or Fosc/4
// - edge bit: falling when one, rising otherwise
// - assign bit routes prescaler to watchdog or timer
// - rate: timer 2^(code+1), watchdog 2^code
// - pull-up disable bit overrides per-pin enables
// - interrupt edge bit: rising one, falling zero
// - overflow flag forwarded only when enabled
// - count write inhibits increment two instruction cycles
// - count write clears prescaler when timer-assigned
// - watchdog clear clears prescaler when watchdog-assigned
// - no prescaler: Fosc/4 source increments every instruction cycle, pin source every selected edge
module ebt_timer #(
  parameter int PS_W = 8,
  parameter int PULLUP_N = 6
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [ebt_pkg::ADDR_W-1:0] wb_adr_in,
  input wire logic [ebt_pkg::DATA_W-1:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  output logic [ebt_pkg::DATA_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic tz_ext_clock_pin_in,
  input wire logic sleep_in,
  input wire logic watchdog_osc_tick_in,
  input wire logic watchdog_clear_instr_in,
  input wire logic [PULLUP_N-1:0] pullup_pin_en_in,
  output logic [PULLUP_N-1:0] pullup_en_out,
  output logic ext_int_edge_sel_out,
  output logic watchdog_tick_out,
  output logic tz_irq_req_out,
  output logic irq_out
);
  import ebt_pkg::*;

  initial begin
    if (PS_W != 8 || PULLUP_N < 1 || PULLUP_N > 8) begin
      $error("ebt_timer: unsupported parameter values");
    end
    if (RATE_W + 1 > PS_W) begin
      $error("ebt_timer: prescaler too narrow for rate field");
    end
    if (INHIBIT_CLKS < 1 || INHIBIT_CLKS > 15) begin
      $error("ebt_timer: inhibit count does not fit");
    end
  end

  logic [7:0] count_q;
  logic [7:0] irq_ctl_q;
  logic [7:0] option_q;
  logic [EV_W-1:0] evt_status_q;
  logic [EV_W-1:0] evt_mask_q;
  logic [PS_W-1:0] ps_q;
  logic [1:0] phase_q;
  logic pin_q;
  logic pend_q;
  logic sync_q;
  logic [3:0] inhibit_q;
  logic ack_q;
  logic [DATA_W-1:0] rdata_q;

  // option field views
  logic tz_clock_source_sel;
  logic tz_source_edge_sel;
  logic prescaler_assign;
  logic [RATE_W-1:0] prescaler_rate;
  logic port_pullup_disable;
  logic ext_int_edge_sel;
  assign port_pullup_disable = option_q[OPT_PULLUP_DIS];
  assign ext_int_edge_sel = option_q[OPT_INT_EDGE];
  assign tz_clock_source_sel = option_q[OPT_CLK_SRC];
  assign tz_source_edge_sel = option_q[OPT_SRC_EDGE];
  assign prescaler_assign = option_q[OPT_PS_ASSIGN];
  assign prescaler_rate = option_q[OPT_RATE_LSB +: RATE_W];

  ebt_src_t src;
  assign src = tz_clock_source_sel ? EBT_SRC_PIN : EBT_SRC_INSTR;

  // bus request decode
  logic req;
  logic wr;
  logic wr_count;
  logic wr_irq_ctl;
  logic wr_option;
  logic wr_status;
  logic wr_mask;
  assign req = wb_cyc_in && wb_stb_in && !ack_q;
  // writes land on the ack edge, request still held by the master
  logic commit;
  assign commit = wb_cyc_in && wb_stb_in && ack_q;
  assign wr = commit && wb_we_in && wb_sel_in[0];
  assign wr_count = wr && (wb_adr_in == OFF_COUNT);
  assign wr_irq_ctl = wr && (wb_adr_in == OFF_IRQ_CONTROL);
  assign wr_option = wr && (wb_adr_in == OFF_OPTION);
  assign wr_status = wr && (wb_adr_in == OFF_EVT_STATUS);
  assign wr_mask = wr && (wb_adr_in == OFF_EVT_MASK);

  // instruction phase counter, phase four ends each instruction cycle
  logic instr_tick;
  assign instr_tick = (phase_q == PH_FOUR);
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // external pin edge detect with edge polarity
  logic pin_edge;
  assign pin_edge = tz_source_edge_sel ? (pin_q && !tz_ext_clock_pin_in)
                                       : (!pin_q && tz_ext_clock_pin_in);
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= tz_ext_clock_pin_in;
    end
  end

  // prescaler input and division
  logic ps_in;
  logic [PS_W-1:0] ps_next;
  logic [PS_W-1:0] tmr_mask;
  logic [PS_W-1:0] wdt_mask;
  logic ps_hit_tmr;
  logic ps_hit_wdt;
  logic ps_clear;
  assign ps_in = prescaler_assign ? watchdog_osc_tick_in
                 : ((src == EBT_SRC_PIN) ? pin_edge : instr_tick);
  assign ps_next = ps_q + PS_W'(1);
  assign tmr_mask = PS_W'((16'h0002 << prescaler_rate) - 16'h0001);
  assign wdt_mask = PS_W'((16'h0001 << prescaler_rate) - 16'h0001);
  assign ps_hit_tmr = ps_in && ((ps_next & tmr_mask) == '0);
  assign ps_hit_wdt = ps_in && ((ps_next & wdt_mask) == '0);
  assign ps_clear = prescaler_assign ? watchdog_clear_instr_in
                                     : wr_count;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ps_q <= '0;
    end else if (ps_clear) begin
      ps_q <= '0;
    end else if (ps_in) begin
      ps_q <= ps_next;
    end
  end

  // timer increment source after prescaler assignment
  logic tmr_event;
  logic wdt_event;
  assign tmr_event = prescaler_assign
                     ? ((src == EBT_SRC_PIN) ? pin_edge : instr_tick)
                     : ps_hit_tmr;
  assign wdt_event = prescaler_assign ? ps_hit_wdt : watchdog_osc_tick_in;

  // pin-sourced events resynchronised at phases two and four
  logic sample_phase;
  assign sample_phase = (phase_q == PH_TWO) || (phase_q == PH_FOUR);
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      if (sample_phase) begin
        sync_q <= pend_q || tmr_event;
        pend_q <= 1'b0;
      end else begin
        sync_q <= 1'b0;
        if (tmr_event) begin
          pend_q <= 1'b1;
        end
      end
    end
  end

  // increment inhibit after a count write
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      inhibit_q <= 4'h0;
    end else if (wr_count) begin
      inhibit_q <= 4'(INHIBIT_CLKS);
    end else if (inhibit_q != 4'h0) begin
      inhibit_q <= inhibit_q - 4'h1;
    end
  end

  // counting source, pin events only after resync
  logic count_src;
  logic tmr_inc;
  logic overflow;
  assign count_src = (src == EBT_SRC_PIN) ? sync_q : tmr_event;
  assign tmr_inc = count_src && (inhibit_q == 4'h0) && !sleep_in;
  assign overflow = tmr_inc && (count_q == 8'hFF);

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_q <= RST_COUNT;
    end else if (wr_count) begin
      count_q <= wb_dat_in[7:0];
    end else if (tmr_inc) begin
      count_q <= count_q + 8'h01;
    end
  end

  // irq_control: overflow flag set wins over software clear
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_ctl_q <= RST_IRQ_CONTROL;
    end else begin
      if (wr_irq_ctl) begin
        irq_ctl_q <= wb_dat_in[7:0];
      end
      if (overflow) begin
        irq_ctl_q[IC_OVF_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      option_q <= RST_OPTION;
    end else if (wr_option) begin
      option_q <= wb_dat_in[7:0];
    end
  end

  // event status: write one to clear, set wins
  logic [EV_W-1:0] evt_set;
  logic [EV_W-1:0] evt_clr;
  assign evt_set = {wdt_event, overflow};
  assign evt_clr = wr_status ? wb_dat_in[EV_W-1:0] : '0;
  // one sticky bit per event
  genvar ei;
  generate
    for (ei = 0; ei < EV_W; ei++) begin : g_evt
      always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          evt_status_q[ei] <= 1'b0;
        end else if (evt_set[ei]) begin
          evt_status_q[ei] <= 1'b1;
        end else if (evt_clr[ei]) begin
          evt_status_q[ei] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evt_mask_q <= RST_EVT_MASK;
    end else if (wr_mask) begin
      evt_mask_q <= wb_dat_in[EV_W-1:0];
    end
  end

  // bus answer: one wait state, unmapped reads zero
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req;
      if (req) begin
        if (wb_adr_in == OFF_COUNT) begin
          rdata_q <= {24'h000000, count_q};
        end else if (wb_adr_in == OFF_IRQ_CONTROL) begin
          rdata_q <= {24'h000000, irq_ctl_q};
        end else if (wb_adr_in == OFF_OPTION) begin
          rdata_q <= {24'h000000, option_q};
        end else if (wb_adr_in == OFF_EVT_STATUS) begin
          rdata_q <= {{(DATA_W-EV_W){1'b0}}, evt_status_q};
        end else if (wb_adr_in == OFF_EVT_MASK) begin
          rdata_q <= {{(DATA_W-EV_W){1'b0}}, evt_mask_q};
        end else begin
          rdata_q <= '0;
        end
      end
    end
  end
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;

  // registered outputs
  logic [PULLUP_N-1:0] pullup_q;
  logic int_edge_q;
  logic wdt_tick_q;
  logic tz_req_q;
  logic irq_q;
  genvar gi;
  generate
    for (gi = 0; gi < PULLUP_N; gi++) begin : g_pullup
      always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          pullup_q[gi] <= 1'b0;
        end else begin
          pullup_q[gi] <= !port_pullup_disable && pullup_pin_en_in[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      int_edge_q <= 1'b1;
      wdt_tick_q <= 1'b0;
      tz_req_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      int_edge_q <= ext_int_edge_sel;
      wdt_tick_q <= wdt_event;
      tz_req_q <= irq_ctl_q[IC_OVF_FLAG] && irq_ctl_q[IC_OVF_IRQ_EN];
      irq_q <= |(evt_status_q & evt_mask_q);
    end
  end
  assign pullup_en_out = pullup_q;
  assign ext_int_edge_sel_out = int_edge_q;
  assign watchdog_tick_out = wdt_tick_q;
  assign tz_irq_req_out = tz_req_q;
  assign irq_out = irq_q;
endmodule // ebt_timer

// file: testbench/ebt_far_model.sv
/* ebt_far_model: external count pin and watchdog oscillator side.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module ebt_far_model (
  input wire logic clk_in,
  output logic pin_out,
  output logic tick_out,
  output logic clr_out
);
  initial begin
    pin_out = 1'b0;
    tick_out = 1'b0;
    clr_out = 1'b0;
  end
  // slow pin pulses, wide high and low phases
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (10) @(posedge clk_in);
      pin_out <= 1'b1;
      repeat (10) @(posedge clk_in);
      pin_out <= 1'b0;
    end
    repeat (10) @(posedge clk_in);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_in);
      tick_out <= 1'b1;
      @(posedge clk_in);
      tick_out <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask
  task automatic clr_pulse;
    @(posedge clk_in);
    clr_out <= 1'b1;
    @(posedge clk_in);
    clr_out <= 1'b0;
  endtask
endmodule // ebt_far_model

// file: testbench/ebt_timer_props.sv
/* ebt_timer_props: port assertions for ebt_timer.
   assumes it is bound onto every ebt_timer instance. */
`timescale 1ns/1ps
module ebt_timer_props #(
  parameter int PULLUP_N = 6
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [ebt_pkg::ADDR_W-1:0] wb_adr_in,
  input wire logic [ebt_pkg::DATA_W-1:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [ebt_pkg::DATA_W-1:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic sleep_in,
  input wire logic [PULLUP_N-1:0] pullup_pin_en_in,
  input wire logic [PULLUP_N-1:0] pullup_en_out,
  input wire logic ext_int_edge_sel_out,
  input wire logic tz_irq_req_out
);
  import ebt_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic req;
  logic wr;
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr = wb_cyc_in && wb_stb_in && wb_ack_out
              && wb_we_in && wb_sel_in[0];
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  ack_latency_a: assert property (req |=> wb_ack_out)
    else $error("ack missing");
  ack_cause_a: assert property ($rose(wb_ack_out)
    |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
  irq_gate_a: assert property (wr && wb_adr_in == OFF_IRQ_CONTROL
    && !wb_dat_in[IC_OVF_IRQ_EN] |=> ##1 !tz_irq_req_out)
    else $error("request while disabled");
  edge_sel_a: assert property (wr && wb_adr_in == OFF_OPTION |=> ##1
    ext_int_edge_sel_out == $past(wb_dat_in[OPT_INT_EDGE], 2))
    else $error("edge select wrong");
  pullup_mask_a: assert property (
    (pullup_en_out & ~$past(pullup_pin_en_in)) == '0)
    else $error("pull-up without pin enable");
  unmapped_read_a: assert property (req && !wb_we_in
    && wb_adr_in > OFF_EVT_MASK |=> wb_dat_out == '0)
    else $error("unmapped read not zero");
  sleep_frozen_a: assert property (sleep_in && !wb_cyc_in
    |-> ##2 $stable(tz_irq_req_out)) else $error("change during sleep");
endmodule // ebt_timer_props
bind ebt_timer ebt_timer_props #(.PULLUP_N(PULLUP_N)) ebt_timer_props_i (.*);

// file: testbench/testbench.sv
/* testbench: drives ebt_timer over wishbone beside the far model.
   assumes ebt_pkg, the checker bind and the far model compiled first. */
`timescale 1ns/1ps
module testbench;
  import ebt_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] dat = '0;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] rdat;
  logic we = 1'b0;
  logic [3:0] sel = 4'hF;
  logic cyc = 1'b0;
  logic sleep = 1'b0;
  logic [5:0] pen = 6'h2A;
  logic [5:0] pout;
  logic ack, pin, tick, clr, esel, wdo, treq, irq;
  int fail_count = 0;
  int check_count = 0;
  int wd_seen = 0;
  int n;
  logic [16:0] rows [10];
  always #25 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (wdo === 1'b1) wd_seen <= wd_seen + 1;
  ebt_timer ebt_timer_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel), .wb_we_in(we),
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_dat_out(rdat), .wb_ack_out(ack),
    .tz_ext_clock_pin_in(pin), .sleep_in(sleep), .watchdog_osc_tick_in(tick),
    .watchdog_clear_instr_in(clr), .pullup_pin_en_in(pen),
    .pullup_en_out(pout), .ext_int_edge_sel_out(esel),
    .watchdog_tick_out(wdo), .tz_irq_req_out(treq), .irq_out(irq));
  ebt_far_model ebt_far_model_i (.clk_in(ref_clk_in), .pin_out(pin),
    .tick_out(tick), .clr_out(clr));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_in);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    if (ack !== 1'b1) begin
      fail_count++;
      $display("Error %0t bus timeout", $time);
      complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  initial begin
    rows = '{{1'b0, OFF_IRQ_CONTROL, 8'h00}, {1'b0, OFF_OPTION, 8'hFF},
      {1'b0, OFF_EVT_MASK, 8'h00}, {1'b0, OFF_COUNT, 8'h00},
      {1'b1, 8'h14, 8'h5A}, {1'b0, 8'h14, 8'h00},
      {1'b1, OFF_IRQ_CONTROL, 8'hC1}, {1'b0, OFF_IRQ_CONTROL, 8'hC1},
      {1'b1, OFF_OPTION, 8'h77}, {1'b0, OFF_OPTION, 8'h77}};
    repeat (8) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][16])
        bus(1'b1, rows[i][15:8], {24'h0, rows[i][7:0]});
      else
        rd(rows[i][15:8], {24'h0, rows[i][7:0]});
    end
    sel <= 4'hE;
    bus(1'b1, OFF_OPTION, 32'h00);
    sel <= 4'hF;
    rd(OFF_OPTION, 32'h77);
    $display("done: register table");
    repeat (2) @(posedge ref_clk_in);
    chk({26'h0, pout}, 32'h2A);
    pen <= 6'h15;
    repeat (2) @(posedge ref_clk_in);
    chk({26'h0, pout}, 32'h15);
    bus(1'b1, OFF_OPTION, 32'hF7);
    repeat (2) @(posedge ref_clk_in);
    chk({26'h0, pout}, 32'h0);
    bus(1'b1, OFF_EVT_MASK, 32'h3);
    bus(1'b1, OFF_OPTION, 32'h28);
    bus(1'b1, OFF_COUNT, 32'h0);
    chk({31'h0, esel}, 32'h0);
    ebt_far_model_i.pulses(5);
    rd(OFF_COUNT, 32'h5);
    bus(1'b1, OFF_OPTION, 32'h38);
    bus(1'b1, OFF_COUNT, 32'h0);
    ebt_far_model_i.pulses(3);
    rd(OFF_COUNT, 32'h3);
    sleep <= 1'b1;
    ebt_far_model_i.pulses(2);
    sleep <= 1'b0;
    rd(OFF_COUNT, 32'h3);
    bus(1'b1, OFF_OPTION, 32'h20);
    bus(1'b1, OFF_COUNT, 32'h0);
    ebt_far_model_i.pulses(4);
    rd(OFF_COUNT, 32'h2);
    $display("done: counter mode and sleep");
    for (int r = -1; r < 3; r++) begin
      int dv;
      dv = (r < 0) ? 4 : (8 << r);
      bus(1'b1, OFF_OPTION, (r < 0) ? 32'h08 : r);
      bus(1'b1, OFF_COUNT, 32'h0);
      repeat (200) @(posedge ref_clk_in);
      bus(1'b0, OFF_COUNT, 32'h0);
      chk({31'h0, q >= 196 / dv - 1 && q <= 196 / dv + 1}, 1);
    end
    $display("done: timer rates");
    bus(1'b1, OFF_OPTION, 32'h08);
    bus(1'b1, OFF_IRQ_CONTROL, 32'h0);
    bus(1'b1, OFF_COUNT, 32'hFD);
    repeat (40) @(posedge ref_clk_in);
    rd(OFF_IRQ_CONTROL, 32'h04);
    chk({31'h0, treq}, 32'h0);
    rd(OFF_EVT_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFF_IRQ_CONTROL, 32'h24);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, treq}, 32'h1);
    repeat (40) @(posedge ref_clk_in);
    rd(OFF_IRQ_CONTROL, 32'h24);
    bus(1'b1, OFF_IRQ_CONTROL, 32'h20);
    rd(OFF_IRQ_CONTROL, 32'h20);
    bus(1'b1, OFF_EVT_MASK, 32'h0);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFF_EVT_MASK, 32'h1);
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFF_EVT_STATUS, 32'h1);
    rd(OFF_EVT_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("done: overflow and interrupt");
    bus(1'b1, OFF_OPTION, 32'h00);
    ebt_far_model_i.clr_pulse();
    bus(1'b1, OFF_COUNT, 32'h0);
    bus(1'b1, OFF_OPTION, 32'h08);
    ebt_far_model_i.clr_pulse();
    bus(1'b1, OFF_OPTION, 32'h0A);
    n = wd_seen;
    ebt_far_model_i.ticks(8);
    chk(wd_seen - n, 2);
    ebt_far_model_i.ticks(3);
    ebt_far_model_i.clr_pulse();
    ebt_far_model_i.ticks(2);
    chk(wd_seen - n, 2);
    ebt_far_model_i.clr_pulse();
    bus(1'b1, OFF_OPTION, 32'h00);
    ebt_far_model_i.ticks(3);
    chk(wd_seen - n, 5);
    $display("done: watchdog prescaler");
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd(OFF_OPTION, 32'hFF);
    chk({31'h0, esel}, 32'h1);
    rd(OFF_IRQ_CONTROL, 32'h0);
    $display("done: second reset");
    complete_run();
  end
endmodule // testbench
